// ==== tmc_pkg.sv ====
/*
 * Package for the timer mode and control block: register offsets, field
 * positions, reset values and clock source codes.
 * Assumes an APB register bus with 32-bit data and one word per register.
 */
package tmc_pkg;
    localparam logic [7:0] TMC_OFS_MODE = 8'h00;
    localparam logic [7:0] TMC_OFS_CTRL = 8'h04;
    localparam logic [7:0] TMC_OFS_COUNT = 8'h08;
    localparam logic [7:0] TMC_OFS_GEN_A = 8'h0C;
    localparam logic [7:0] TMC_OFS_GEN_B = 8'h10;
    localparam logic [7:0] TMC_OFS_GEN_C = 8'h14;
    localparam logic [7:0] TMC_OFS_GEN_D = 8'h18;
    localparam logic [7:0] TMC_OFS_STAT = 8'h1C;
    localparam int TMC_BIT_RUN = 7;
    localparam int TMC_BIT_BUF_B = 5;
    localparam int TMC_BIT_BUF_A = 4;
    localparam int TMC_BIT_PWM_D = 2;
    localparam int TMC_BIT_PWM_C = 1;
    localparam int TMC_BIT_PWM_B = 0;
    localparam int TMC_BIT_CLR_A = 7;
    localparam int TMC_CKS_LSB = 4;
    localparam logic [7:0] TMC_MODE_RSV_MASK = 8'h48;
    localparam logic [7:0] TMC_MODE_RESET = 8'h48;
    localparam logic [7:0] TMC_CTRL_RESET = 8'h00;
    localparam logic [15:0] TMC_GR_RESET = 16'hFFFF;
    localparam logic [2:0] TMC_CKS_EXT = 3'h7;
    localparam logic [2:0] TMC_CKS_SUB1 = 3'h4;
    localparam logic [2:0] TMC_CKS_SUB4 = 3'h5;
    localparam logic [2:0] TMC_CKS_SUB16 = 3'h6;
    localparam int TMC_PRE_W = 4;
endpackage

// ==== tmc_chan.sv ====
/*
 * One compare channel: match detect and the output pin level.
 * Assumes the count and register values come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module tmc_chan (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Compare inputs
    input wire logic tick_in,
    input wire logic [15:0] count_in,
    input wire logic [15:0] cmp_in,
    input wire logic [15:0] period_in,
    input wire logic pwm_in,
    input wire logic init_level_in,
    input wire logic init_wr_in,
    // Results
    output logic match_out,
    output logic level_out
);
    always_comb begin
        match_out = tick_in && (count_in == cmp_in);
    end

    // PWM drives high at the period match, low at this channel's match.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            level_out <= 1'b0;
        end else if (init_wr_in) begin
            level_out <= init_level_in;
        end else if (pwm_in && tick_in && count_in == period_in) begin
            level_out <= 1'b1;
        end else if (match_out) begin
            level_out <= pwm_in ? 1'b0 : ~level_out;
        end
    end
endmodule
`default_nettype wire

// ==== tmc_top.sv ====
/*
 * Timer mode and control block: 16-bit counter with four compare channels,
 * clock source selection, buffer pairing and PWM, behind an APB slave.
 * Assumes sub-clock and event inputs are synchronous to core_clk_in.
 */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tmc_top
    import tmc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Count sources
    input wire logic sub_clk_in,
    input wire logic external_event_input_in,
    // Channel pins and overflow flag
    output logic [3:0] channel_pin_out,
    output logic overflow_flag_out
);
    import tmc_pkg::*;

    logic [7:0] timer_mode_q;
    logic [7:0] timer_control_q;
    logic [15:0] timer_count_q;
    logic [15:0] gr_q [4];
    logic overflow_q;
    logic [TMC_PRE_W-1:0] pre_q;
    logic sub_q;
    logic ev_q;
    logic [3:0] subdiv_q;
    logic tick;
    logic [3:0] match;
    logic [3:0] level;
    logic [3:0] pwm_sel;
    logic wr_en;
    logic rd_en;
    logic ctrl_wr;
    logic [2:0] cks;
    logic sub_rise;
    logic [3:0] ch_tick;

    assign wr_en = psel_in && penable_in && pwrite_in;
    assign rd_en = psel_in && penable_in && !pwrite_in;
    assign ctrl_wr = wr_en && paddr_in == TMC_OFS_CTRL;
    assign cks = timer_control_q[TMC_CKS_LSB+2:TMC_CKS_LSB];
    assign sub_rise = sub_clk_in && !sub_q;

    // Zero-wait APB: every access completes in its first access cycle.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && paddr_in > TMC_OFS_STAT;
        end
    end

    // Register data is latched in the setup cycle so prdata is a flop.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            unique case (paddr_in)
                TMC_OFS_MODE: prdata_out <= {24'h0,
                    timer_mode_q | TMC_MODE_RSV_MASK};
                TMC_OFS_CTRL: prdata_out <= {24'h0, timer_control_q};
                TMC_OFS_COUNT: prdata_out <= {16'h0, timer_count_q};
                TMC_OFS_GEN_A: prdata_out <= {16'h0, gr_q[0]};
                TMC_OFS_GEN_B: prdata_out <= {16'h0, gr_q[1]};
                TMC_OFS_GEN_C: prdata_out <= {16'h0, gr_q[2]};
                TMC_OFS_GEN_D: prdata_out <= {16'h0, gr_q[3]};
                TMC_OFS_STAT: prdata_out <= {24'h0, overflow_q, 3'h7,
                    4'h0};
                default: prdata_out <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            timer_mode_q <= TMC_MODE_RESET;
        end else if (wr_en && pready_out && paddr_in == TMC_OFS_MODE) begin
            timer_mode_q <= pwdata_in[7:0] | TMC_MODE_RSV_MASK;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            timer_control_q <= TMC_CTRL_RESET;
        end else if (ctrl_wr && pready_out) begin
            timer_control_q <= pwdata_in[7:0];
        end
    end

    // Prescalers for the system clock and the sampled sub-clock.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pre_q <= '0;
            sub_q <= 1'b0;
            ev_q <= 1'b0;
            subdiv_q <= 4'h0;
        end else begin
            pre_q <= pre_q + 1'b1;
            sub_q <= sub_clk_in;
            ev_q <= external_event_input_in;
            if (sub_rise) begin
                subdiv_q <= subdiv_q + 4'h1;
            end
        end
    end

    always_comb begin
        unique case (cks)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                // Tick whenever the low code bits of the prescaler are zero.
                tick = (pre_q[2:0] & ((3'h1 << cks[1:0]) - 3'h1)) ==
                    3'h0;
            end
            TMC_CKS_SUB1: tick = sub_rise;
            TMC_CKS_SUB4: tick = sub_rise && subdiv_q[1:0] == 2'h3;
            TMC_CKS_SUB16: tick = sub_rise && subdiv_q == 4'hF;
            TMC_CKS_EXT: tick = external_event_input_in && !ev_q;
        endcase
        tick = tick && timer_mode_q[TMC_BIT_RUN];
    end

    assign pwm_sel = {timer_mode_q[TMC_BIT_PWM_D],
                      timer_mode_q[TMC_BIT_PWM_C],
                      timer_mode_q[TMC_BIT_PWM_B], 1'b0};

    // A buffer register only holds data, so its own channel stops matching.
    assign ch_tick = {tick && !timer_mode_q[TMC_BIT_BUF_B],
                      tick && !timer_mode_q[TMC_BIT_BUF_A],
                      tick, tick};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            tmc_chan u_chan (
                .core_clk_in(core_clk_in),
                .sys_rst_in(sys_rst_in),
                .tick_in(ch_tick[gi]),
                .count_in(timer_count_q),
                .cmp_in(gr_q[gi]),
                .period_in(gr_q[0]),
                .pwm_in(pwm_sel[gi]),
                .init_level_in(pwdata_in[gi]),
                .init_wr_in(ctrl_wr && pready_out),
                .match_out(match[gi]),
                .level_out(level[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            timer_count_q <= 16'h0;
        end else if (wr_en && pready_out && paddr_in == TMC_OFS_COUNT) begin
            timer_count_q <= pwdata_in[15:0];
        end else if (tick) begin
            if (timer_control_q[TMC_BIT_CLR_A] && match[0]) begin
                timer_count_q <= 16'h0;
            end else begin
                timer_count_q <= timer_count_q + 16'h1;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            overflow_q <= 1'b0;
        end else if (tick && timer_count_q == 16'hFFFF) begin
            overflow_q <= 1'b1;
        end else if (wr_en && pready_out && paddr_in == TMC_OFS_STAT &&
                     !pwdata_in[7]) begin
            overflow_q <= 1'b0;
        end
    end

    // Software writes win over buffer transfers in the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 4; i++) begin
                gr_q[i] <= TMC_GR_RESET;
            end
        end else begin
            if (timer_mode_q[TMC_BIT_BUF_A] && match[0]) begin
                gr_q[0] <= gr_q[2];
            end
            if (timer_mode_q[TMC_BIT_BUF_B] && match[1]) begin
                gr_q[1] <= gr_q[3];
            end
            if (wr_en && pready_out) begin
                unique case (paddr_in)
                    TMC_OFS_GEN_A: gr_q[0] <= pwdata_in[15:0];
                    TMC_OFS_GEN_B: gr_q[1] <= pwdata_in[15:0];
                    TMC_OFS_GEN_C: gr_q[2] <= pwdata_in[15:0];
                    TMC_OFS_GEN_D: gr_q[3] <= pwdata_in[15:0];
                    default: ;
                endcase
            end
        end
    end

    // In buffer mode C and D match nothing on their pins; they only hold data.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            channel_pin_out <= 4'h0;
            overflow_flag_out <= 1'b0;
        end else begin
            channel_pin_out <= level;
            overflow_flag_out <= overflow_q;
        end
    end

    AST_RUN_HALT: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        !timer_mode_q[TMC_BIT_RUN] && !wr_en |=> $stable(timer_count_q))
        else $error("count moved while halted");
    AST_RSV_ONE: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (timer_mode_q & TMC_MODE_RSV_MASK) == TMC_MODE_RSV_MASK)
        else $error("reserved mode bits not one");
    AST_CLR_A: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        tick && match[0] && timer_control_q[TMC_BIT_CLR_A] && !wr_en
        |=> timer_count_q == 16'h0)
        else $error("count not cleared on match A");
    AST_WRAP: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        tick && timer_count_q == 16'hFFFF && !wr_en |=> overflow_q)
        else $error("overflow not flagged");
    AST_BUF_A: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        timer_mode_q[TMC_BIT_BUF_A] && match[0] && !wr_en
        |=> gr_q[0] == $past(gr_q[2]))
        else $error("buffer A not copied");
    AST_BUF_B: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        timer_mode_q[TMC_BIT_BUF_B] && match[1] && !wr_en
        |=> gr_q[1] == $past(gr_q[3]))
        else $error("buffer B not copied");
    sequence s_level_write;
        ctrl_wr && pready_out;
    endsequence

    // Level flop then output flop: the written level shows two edges on.
    sequence s_pin_follows;
        ##2 channel_pin_out == $past(pwdata_in[3:0], 2);
    endsequence

    AST_INIT_LVL: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_level_write |-> s_pin_follows)
        else $error("initial level not applied");
    AST_EXT_TICK: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        cks == TMC_CKS_EXT && tick |-> external_event_input_in && !ev_q)
        else $error("external tick without rising edge");
    AST_SUB_TICK: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        cks == TMC_CKS_SUB1 && tick |-> sub_rise)
        else $error("sub-clock tick without rising edge");

    // PWM: period match sets a pin, the channel's own match clears it.
    sequence s_pwm_b_set;
        ch_tick[1] && pwm_sel[1] && timer_count_q == gr_q[0] && !ctrl_wr;
    endsequence
    sequence s_pwm_b_clr;
        ch_tick[1] && pwm_sel[1] && timer_count_q == gr_q[1] &&
            timer_count_q != gr_q[0] && !ctrl_wr;
    endsequence
    sequence s_pwm_c_set;
        ch_tick[2] && pwm_sel[2] && timer_count_q == gr_q[0] && !ctrl_wr;
    endsequence
    sequence s_pwm_c_clr;
        ch_tick[2] && pwm_sel[2] && timer_count_q == gr_q[2] &&
            timer_count_q != gr_q[0] && !ctrl_wr;
    endsequence
    sequence s_pwm_d_set;
        ch_tick[3] && pwm_sel[3] && timer_count_q == gr_q[0] && !ctrl_wr;
    endsequence
    sequence s_pwm_d_clr;
        ch_tick[3] && pwm_sel[3] && timer_count_q == gr_q[3] &&
            timer_count_q != gr_q[0] && !ctrl_wr;
    endsequence

    AST_PWM_B_SET: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_b_set |=> level[1])
        else $error("PWM B not set at period");
    AST_PWM_B_CLR: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_b_clr |=> !level[1])
        else $error("PWM B not cleared at match");
    AST_PWM_C_SET: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_c_set |=> level[2])
        else $error("PWM C not set at period");
    AST_PWM_C_CLR: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_c_clr |=> !level[2])
        else $error("PWM C not cleared at match");
    AST_PWM_D_SET: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_d_set |=> level[3])
        else $error("PWM D not set at period");
    AST_PWM_D_CLR: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        s_pwm_d_clr |=> !level[3])
        else $error("PWM D not cleared at match");
endmodule
`default_nettype wire

// ==== test_timer_mode_control.sv ====
/*
 * Self-checking bench for the timer mode and control block over APB.
 * Assumes a free-running sub-clock made here and a bench-driven event pin.
 */
`timescale 1ns/1ps
`default_nettype none
module test_timer_mode_control;
    import tmc_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic sub_clk_in = 1'b0;
    logic external_event_input_in = 1'b0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [3:0] channel_pin_out;
    logic overflow_flag_out;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic sub_div_q = 1'b0;
    logic [31:0] r;
    int failures = 0;
    int checked = 0;
    int seed = 53;
    int n;
    int delta[7] = '{256, 128, 64, 32, 64, 16, 4};

    tmc_top u_dut (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .sub_clk_in(sub_clk_in),
        .external_event_input_in(external_event_input_in),
        .channel_pin_out(channel_pin_out),
        .overflow_flag_out(overflow_flag_out)
    );

    always #2 core_clk_in = ~core_clk_in;

    // Sub-clock rises every fourth cycle, so any 256-cycle window holds 64.
    always @(posedge core_clk_in) begin
        sub_div_q <= ~sub_div_q;
        if (sub_div_q) begin
            sub_clk_in <= ~sub_clk_in;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h, expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic err);
        int i;
        notes.push_back({~wr, err, exp});
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        i = 0;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1) begin
            i++;
            if (i > 20) begin
                failures++;
                wrap_up();
            end
            @(posedge core_clk_in);
        end
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    // The run window spans t edges between the two mode writes taking effect.
    task automatic span(input logic [7:0] mode, input int t);
        wr(TMC_OFS_MODE, {24'h0, mode | 8'h80});
        repeat (t - 3) @(posedge core_clk_in);
        wr(TMC_OFS_MODE, {24'h0, mode});
    endtask

    always @(posedge core_clk_in) begin
        if (pready_out === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                check({31'h0, pslverr_out}, {31'h0, note[32]});
                if (note[33]) begin
                    check(prdata_out, note[31:0]);
                end
            end
        end
    end

    initial begin
        repeat (20) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        check({28'h0, channel_pin_out}, 32'h0);
        rd(TMC_OFS_MODE, 32'h48);
        rd(TMC_OFS_CTRL, 32'h0);
        for (n = 0; n < 4; n++) begin
            rd(TMC_OFS_GEN_A + 8'(4 * n), 32'hFFFF);
        end
        r = $random(seed) & 32'h77;
        wr(TMC_OFS_MODE, r);
        rd(TMC_OFS_MODE, r | 32'h48);
        wr(TMC_OFS_MODE, 32'h0);
        rd(TMC_OFS_MODE, 32'h48);
        apb(1'b1, 8'h20, 32'hFF, 32'h0, 1'b1);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
        rd(TMC_OFS_CTRL, 32'h0);
        repeat (4) begin
            r = $random(seed) & 32'hF;
            wr(TMC_OFS_CTRL, r);
            repeat (3) @(posedge core_clk_in);
            check({28'h0, channel_pin_out}, r);
        end
        wr(TMC_OFS_COUNT, 32'h1234);
        repeat (50) @(posedge core_clk_in);
        rd(TMC_OFS_COUNT, 32'h1234);
        for (n = 0; n < 7; n++) begin
            r = $random(seed) & 32'hFFFF;
            wr(TMC_OFS_CTRL, 32'(n) << 4);
            wr(TMC_OFS_COUNT, r);
            span(8'h00, 256);
            rd(TMC_OFS_COUNT, (r + delta[n]) & 32'hFFFF);
        end
        wr(TMC_OFS_CTRL, 32'h70);
        wr(TMC_OFS_COUNT, 32'h0);
        n = 5 + ($random(seed) & 15);
        wr(TMC_OFS_MODE, 32'h80);
        repeat (n) begin
            @(posedge core_clk_in);
            external_event_input_in <= 1'b1;
            repeat (2) @(posedge core_clk_in);
            external_event_input_in <= 1'b0;
            @(posedge core_clk_in);
        end
        repeat (4) @(posedge core_clk_in);
        wr(TMC_OFS_MODE, 32'h0);
        rd(TMC_OFS_COUNT, 32'(n));
        wr(TMC_OFS_GEN_A, 32'h9);
        wr(TMC_OFS_CTRL, 32'h80);
        wr(TMC_OFS_COUNT, 32'h0);
        span(8'h00, 256);
        rd(TMC_OFS_COUNT, 32'h6);
        wr(TMC_OFS_GEN_A, 32'hFFFF);
        wr(TMC_OFS_CTRL, 32'h0);
        wr(TMC_OFS_STAT, 32'h0);
        wr(TMC_OFS_COUNT, 32'hFFF0);
        repeat (2) @(posedge core_clk_in);
        check({31'h0, overflow_flag_out}, 32'h0);
        span(8'h00, 32);
        rd(TMC_OFS_COUNT, 32'h10);
        check({31'h0, overflow_flag_out}, 32'h1);
        for (n = 0; n < 2; n++) begin
            wr(TMC_OFS_GEN_A, 32'h14);
            wr(TMC_OFS_GEN_B, 32'h14);
            wr(TMC_OFS_GEN_C, 32'h1E);
            wr(TMC_OFS_GEN_D, 32'h1E);
            wr(TMC_OFS_CTRL, 32'h80);
            wr(TMC_OFS_COUNT, 32'h0);
            span((n == 1) ? 8'h30 : 8'h00, 64);
            rd(TMC_OFS_GEN_A, (n == 1) ? 32'h1E : 32'h14);
            rd(TMC_OFS_GEN_B, (n == 1) ? 32'h1E : 32'h14);
        end
        // PWM on B to D with period 9: 260 ticks end on the period match,
        // where plain toggling would leave every pin low.
        wr(TMC_OFS_GEN_A, 32'h9);
        wr(TMC_OFS_GEN_B, 32'h4);
        wr(TMC_OFS_GEN_C, 32'h2);
        wr(TMC_OFS_GEN_D, 32'h7);
        wr(TMC_OFS_CTRL, 32'h80);
        wr(TMC_OFS_COUNT, 32'h0);
        span(8'h07, 260);
        repeat (3) @(posedge core_clk_in);
        check({28'h0, channel_pin_out}, 32'hE);
        rd(TMC_OFS_COUNT, 32'h0);
        repeat (2) @(posedge core_clk_in);
        wrap_up();
    end
endmodule
`default_nettype wire
